/* File: rtl/adf_pkg.sv */
package adf_pkg;

    // ==========================================================
    // Bus address and register map
    localparam logic [6:0] ADF_DEV_ADDR     = 7'h6C;
    localparam logic [7:0] ADF_REG_FAULT    = 8'h01;
    localparam logic [7:0] ADF_REG_STATUS   = 8'h02;
    localparam logic [7:0] ADF_REG_CTRL     = 8'h03;
    localparam logic [7:0] ADF_CTRL_RESET   = 8'h00;

    // ==========================================================
    // Latched fault register bit positions
    localparam int ADF_FB_DIAG  = 2;
    localparam int ADF_FB_OC    = 3;
    localparam int ADF_FB_UV    = 4;
    localparam int ADF_FB_OV    = 5;
    localparam int ADF_FB_DC    = 6;

    // Status register bit positions
    localparam int ADF_SB_GND   = 0;
    localparam int ADF_SB_SUP   = 1;
    localparam int ADF_SB_OPEN  = 2;
    localparam int ADF_SB_SHORT = 3;
    localparam int ADF_SB_THERM = 4;
    localparam int ADF_SB_DIAG  = 5;
    localparam int ADF_SB_PLAY  = 6;
    localparam int ADF_SB_HIZ   = 7;

    // Limiter field of the control register
    localparam int ADF_LIM_LSB  = 0;
    localparam int ADF_LIM_W    = 4;

    // ==========================================================
    // Timing
    localparam int    ADF_CLK_HZ     = 40_000_000;
    localparam int    ADF_DIAG_MS    = 229;
    localparam int    ADF_WAKE_MS    = 1;
    localparam int    ADF_DIAG_CYC   = ADF_CLK_HZ / 1000 * ADF_DIAG_MS;
    localparam int    ADF_WAKE_CYC   = ADF_CLK_HZ / 1000 * ADF_WAKE_MS;
    localparam int    ADF_CHECK_MAX  = 5;

    // ==========================================================
    // Types
    typedef enum logic [2:0] {
        ST_OFF, ST_DIAG, ST_PLAY, ST_FAULT, ST_THERM
    } adf_state_e;

    typedef struct packed {
        logic oc;
        logic dc;
        logic therm;
        logic low;
        logic high;
    } adf_trip_s;

    typedef struct packed {
        logic gnd;
        logic sup;
        logic open;
        logic short_ld;
        logic heavy_cap;
    } adf_load_s;

endpackage

/* File: rtl/adf_i2c_target.sv */
`timescale 1ns/1ps

module adf_i2c_target
    import adf_pkg::*;
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    input  wire logic       enable,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    // Register port
    output logic [7:0]      reg_addr,
    output logic [7:0]      wr_data,
    output logic            wr_pulse,
    input  wire logic [7:0] rd_data
);

    typedef enum logic [2:0] {
        B_IDLE, B_ADDR, B_ACK, B_RX, B_TX, B_TXACK, B_SKIP
    } adf_bus_e;

    // ==========================================================
    // Input sync: three stages, a change counts when 2 and 3 agree
    logic [2:0] scl_q, sda_q;
    logic       scl_f_q, sda_f_q, scl_p_q, sda_p_q;
    always_ff @(posedge clk)
    begin
        scl_q <= {scl_q[1:0], scl_in};
        sda_q <= {sda_q[1:0], sda_in};
        if (sys_rst)
        begin
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end
        else
        begin
            if (scl_q[1] == scl_q[2])
                scl_f_q <= scl_q[2];
            if (sda_q[1] == sda_q[2])
                sda_f_q <= sda_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;
        end
    end

    logic scl_rise, scl_fall, start_c, stop_c;
    // START and STOP are SDA edges while SCL is high
    assign scl_rise = scl_f_q & ~scl_p_q;
    assign scl_fall = ~scl_f_q & scl_p_q;
    assign start_c  = scl_f_q & scl_p_q & sda_p_q & ~sda_f_q;
    assign stop_c   = scl_f_q & scl_p_q & ~sda_p_q & sda_f_q;

    // ==========================================================
    // Byte engine; never holds SCL, so no clock stretching
    adf_bus_e   st_q;
    logic [7:0] sh_q;
    logic [3:0] bit_q;
    logic       rd_q, sub_q, ackd_q;
    logic [7:0] ptr_q;

    assign reg_addr = ptr_q;
    assign sda_out  = 1'b0;

    always_ff @(posedge clk)
    begin
        wr_pulse <= 1'b0;
        if (sys_rst || !enable)
        begin
            st_q     <= B_IDLE;
            sh_q     <= 8'h00;
            bit_q    <= 4'h0;
            rd_q     <= 1'b0;
            sub_q    <= 1'b0;
            ackd_q   <= 1'b0;
            ptr_q    <= 8'h00;
            wr_data  <= 8'h00;
            sda_oe   <= 1'b0;      // Lines released while off
        end
        else if (start_c)
        begin
            st_q   <= B_ADDR;
            bit_q  <= 4'h0;
            ackd_q <= 1'b0;
            sda_oe <= 1'b0;
        end
        else if (stop_c)
        begin
            st_q   <= B_IDLE;
            sda_oe <= 1'b0;
        end
        else
        begin
            case (st_q)
                B_ADDR, B_RX:
                begin
                    if (scl_rise)
                    begin
                        sh_q  <= {sh_q[6:0], sda_f_q}; // MSB first
                        bit_q <= bit_q + 4'h1;
                    end
                    if (scl_fall && bit_q == 4'd8)
                    begin
                        bit_q <= 4'h0;
                        if (st_q == B_ADDR)
                        begin
                            if (sh_q[7:1] == ADF_DEV_ADDR)
                            begin
                                rd_q   <= sh_q[0];
                                sub_q  <= ~sh_q[0];
                                sda_oe <= 1'b1;
                                st_q   <= B_ACK;
                            end
                            else
                                st_q <= B_SKIP; // Stay off the bus
                        end
                        else
                        begin
                            // Ack every written byte
                            sda_oe <= 1'b1;
                            st_q   <= B_ACK;
                            if (sub_q)
                            begin
                                ptr_q <= sh_q;
                                sub_q <= 1'b0;
                            end
                            else
                            begin
                                wr_data  <= sh_q;
                                wr_pulse <= 1'b1;
                            end
                        end
                    end
                end
                B_ACK:
                    // Ack held low for the whole ack clock
                    // After a master ack the next byte loads at once
                    if (scl_fall || ackd_q)
                    begin
                        ackd_q <= 1'b0;
                        if (rd_q)
                        begin
                            sh_q   <= rd_data;
                            sda_oe <= ~rd_data[7];
                            bit_q  <= 4'h1;
                            st_q   <= B_TX;
                        end
                        else
                        begin
                            sda_oe <= 1'b0;
                            st_q   <= B_RX;
                        end
                    end
                B_TX:
                    if (scl_fall)
                    begin
                        if (bit_q == 4'd8)
                        begin
                            sda_oe <= 1'b0;
                            st_q   <= B_TXACK;
                        end
                        else
                        begin
                            sda_oe <= ~sh_q[3'd7 - bit_q[2:0]];
                            bit_q  <= bit_q + 4'h1;
                        end
                    end
                B_TXACK:
                begin
                    if (scl_rise)
                        ackd_q <= ~sda_f_q;
                    if (scl_fall)
                    begin
                        if (ackd_q)
                        begin
                            // Next subaddress after an ack
                            ptr_q <= ptr_q + 8'h01;
                            st_q  <= B_ACK;
                        end
                        else
                            st_q <= B_SKIP;
                    end
                end
                B_SKIP, B_IDLE: ;
                default: st_q <= B_IDLE;
            endcase
            // Write pointer advances after each data byte
            if (wr_pulse)
                ptr_q <= ptr_q + 8'h01;
        end
    end

endmodule

/* File: rtl/adf_ctrl.sv */
`timescale 1ns/1ps

// Function
// - Diagnostic starts on shutdown release and after any protection fault clears.
// - Outputs Hi-Z during diagnostic; load classified gnd, supply, open, short.
// - One diagnostic pass lasts about 229 ms of clock.
// - Load fault repeats check up to five times, then checks continuously.
// - Normal load ends diagnostic and starts play.
// - Overvoltage reruns diagnostic after every event, one cycle later on odd events.
// - Open load or heavy cap goes to registers only; all else also asserts alert.
// - Thermal, high or low supply fault aborts a running diagnostic.
// - Overcurrent forces Hi-Z, asserts alert, records status.
// - Dc offset monitored in play; asserts alert and records.
// - Thermal trip shuts output, alerts, records, recovers when cleared.
// - Low supply asserts alert and resets bus registers.
// - Supply-loss reset releases bus lines; restart with default registers.
// - High supply alerts in shutdown and active modes, records only when active.
// - Limiter level from control register 0x03 field, both polarities.
// - Bus answers about 1 ms after shutdown pin goes high.
// - Target only, up to 400 kbit/s, no stretching, no arbitration.
// - Bytes of 8 bits, MSB first, each acknowledged by receiver.
// - SDA changes while SCL low; START and STOP marked by SDA edges.
// - Matching 7-bit address acknowledged by SDA low through ack clock.
// - Single write: address, subaddress, data; each byte acknowledged.
// - Single read: subaddress write, repeated START, read one byte.
// - Multi-byte read advances subaddress after each acknowledged byte.
// - Fault 0x01 and status 0x02 read-only, control 0x03 read-write.
// - Fault bits: D2 diag, D3 overcurrent, D4 low, D5 high, D6 dc.
// - In shutdown bus lines released and registers held reset.

module adf_ctrl
    import adf_pkg::*;
#(
    parameter int DIAG_CYC = ADF_DIAG_CYC,
    parameter int WAKE_CYC = ADF_WAKE_CYC
)
(
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       sys_rst,
    // Device pins
    input  wire logic       shutdown_n,
    input  wire logic       por_n,
    output logic            alert_n_out,
    output logic            alert_n_oe,
    // Bus pins
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            scl_out,
    output logic            scl_oe,
    output logic            sda_out,
    output logic            sda_oe,
    // Analog monitor inputs
    input  wire adf_trip_s  trip,
    input  wire adf_load_s  load,
    input  wire logic       load_valid,
    // Output stage control
    output logic            out_hiz,
    output logic            out_play,
    output logic            diag_bias,
    output logic [3:0]      limit_level
);

    // ==========================================================
    // Pin inputs through three stages; change when 2 and 3 agree
    logic [2:0] sd_q, por_q;
    logic       sd_f_q, por_f_q, sd_p_q;
    always_ff @(posedge clk)
    begin
        sd_q  <= {sd_q[1:0], shutdown_n};
        por_q <= {por_q[1:0], por_n};
        if (sys_rst)
        begin
            sd_f_q  <= 1'b0;
            por_f_q <= 1'b0;
            sd_p_q  <= 1'b0;
        end
        else
        begin
            if (sd_q[1] == sd_q[2])
                sd_f_q <= sd_q[2];
            if (por_q[1] == por_q[2])
                por_f_q <= por_q[2];
            sd_p_q <= sd_f_q;
        end
    end

    logic active, sd_rise;
    // Shutdown holds all but the high-supply alert reset; supply loss also holds the alert reset
    assign active  = sd_f_q & por_f_q;
    assign sd_rise = sd_f_q & ~sd_p_q;

    // Trip inputs are analog comparators, synchronised the same way
    logic [2:0][4:0] tr_q;
    logic [4:0]      trf_q, trp_q;
    always_ff @(posedge clk)
    begin
        tr_q <= {tr_q[1:0], trip};
        if (sys_rst)
        begin
            trf_q <= 5'h0_0;
            trp_q <= 5'h0_0;
        end
        else
        begin
            for (int i = 0; i < 5; i++)
                if (tr_q[1][i] == tr_q[2][i])
                    trf_q[i] <= tr_q[2][i];
            trp_q <= trf_q;
        end
    end

    adf_trip_s t, t_rise;
    assign t      = adf_trip_s'(trf_q);
    assign t_rise = adf_trip_s'(trf_q & ~trp_q);

    // ==========================================================
    // Bus wake-up delay after shutdown release
    logic [$clog2(WAKE_CYC+1)-1:0] wake_q;
    logic                          bus_en;
    always_ff @(posedge clk)
    begin
        if (sys_rst || !active)
            wake_q <= '0;
        else if (wake_q != WAKE_CYC[$bits(wake_q)-1:0])
            wake_q <= wake_q + 1'b1;
    end
    assign bus_en = active && wake_q == WAKE_CYC[$bits(wake_q)-1:0];

    // ==========================================================
    // Bus target
    logic [7:0] reg_addr, wr_data, rd_data;
    logic       wr_pulse;
    adf_i2c_target u_bus
    (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .enable   (bus_en),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .sda_out  (sda_out),
        .sda_oe   (sda_oe),
        .reg_addr (reg_addr),
        .wr_data  (wr_data),
        .wr_pulse (wr_pulse),
        .rd_data  (rd_data)
    );
    // SCL is never driven
    assign scl_out = 1'b0;
    assign scl_oe  = 1'b0;

    // ==========================================================
    // Operating state machine
    adf_state_e st_q;
    logic [$clog2(DIAG_CYC+1)-1:0] dcnt_q;
    logic [2:0] chk_q;
    logic       ov_odd_q;
    logic       pass_end, load_bad, abort_diag, hard_fault;

    assign pass_end   = dcnt_q == DIAG_CYC[$bits(dcnt_q)-1:0];
    assign load_bad   = load.gnd | load.sup | load.open | load.short_ld
                      | load.heavy_cap;
    assign abort_diag = t.therm | t.high | t.low;
    assign hard_fault = t.oc | t.dc | t.therm | t.high | t.low;

    always_ff @(posedge clk)
    begin
        if (sys_rst || !active)
        begin
            st_q     <= ST_OFF;
            dcnt_q   <= '0;
            chk_q    <= 3'h0;
            ov_odd_q <= 1'b0;
        end
        else
        begin
            // Odd/even tracking of high-supply events
            if (t_rise.high)
                ov_odd_q <= ~ov_odd_q;
            case (st_q)
                ST_OFF:
                    if (sd_rise || sd_f_q)
                    begin
                        st_q   <= ST_DIAG;
                        dcnt_q <= '0;
                        chk_q  <= 3'h0;
                    end
                ST_DIAG:
                    if (abort_diag)
                        st_q <= t.therm ? ST_THERM : ST_FAULT;
                    else if (pass_end && load_valid)
                    begin
                        dcnt_q <= '0;
                        if (!load_bad)
                            st_q <= ST_PLAY;
                        else if (chk_q != 3'(ADF_CHECK_MAX))
                            chk_q <= chk_q + 3'h1;  // Repeat, then loop
                    end
                    else if (!pass_end)
                        dcnt_q <= dcnt_q + 1'b1;
                ST_PLAY:
                    if (t.therm)
                        st_q <= ST_THERM;
                    else if (hard_fault)
                        st_q <= ST_FAULT;
                ST_FAULT:
                    if (!hard_fault)
                    begin
                        // Odd high-supply event count delays the rerun by one cycle
                        if (t_rise.high || !ov_odd_q || trp_q == 5'h0_0)
                            st_q <= ST_DIAG;
                        dcnt_q <= '0;
                        chk_q  <= 3'h0;
                    end
                ST_THERM:
                    if (!t.therm)
                    begin
                        st_q   <= ST_DIAG;
                        dcnt_q <= '0;
                        chk_q  <= 3'h0;
                    end
                default: st_q <= ST_OFF;
            endcase
        end
    end

    // ==========================================================
    // Register file; low supply resets it like shutdown
    logic [7:0] fault_q, status_q, ctrl_q;
    logic       clr_regs;
    assign clr_regs = sys_rst || !active || t.low;

    always_ff @(posedge clk)
    begin
        if (clr_regs)
            ctrl_q <= ADF_CTRL_RESET;
        else if (wr_pulse && reg_addr == ADF_REG_CTRL)
            ctrl_q <= wr_data;  // Only control is writable
    end

    // Fault latches: set on event; bits D0 D1 D7 stay zero
    always_ff @(posedge clk)
    begin
        if (sys_rst || !active)
            fault_q <= 8'h00;
        else
        begin
            if (t.low)
                fault_q <= 8'h00;
            if (t.oc)
                fault_q[ADF_FB_OC] <= 1'b1;
            if (t.dc && st_q == ST_PLAY)
                fault_q[ADF_FB_DC] <= 1'b1;
            if (t.high)
                fault_q[ADF_FB_OV] <= 1'b1;
            if (t.low)
                fault_q[ADF_FB_UV] <= 1'b1;
            if (st_q == ST_DIAG && pass_end && load_valid && load_bad)
                fault_q[ADF_FB_DIAG] <= 1'b1;
        end
    end

    // Status: latest diagnostic classification and live state
    always_ff @(posedge clk)
    begin
        if (clr_regs)
            status_q <= 8'h00;
        else
        begin
            if (st_q == ST_DIAG && pass_end && load_valid)
            begin
                status_q[ADF_SB_GND]   <= load.gnd;
                status_q[ADF_SB_SUP]   <= load.sup;
                status_q[ADF_SB_OPEN]  <= load.open;
                status_q[ADF_SB_SHORT] <= load.short_ld;
            end
            status_q[ADF_SB_THERM] <= t.therm;
            status_q[ADF_SB_DIAG]  <= st_q == ST_DIAG;
            status_q[ADF_SB_PLAY]  <= st_q == ST_PLAY;
            status_q[ADF_SB_HIZ]   <= st_q != ST_PLAY;
        end
    end

    // Read mux, unmapped subaddresses read zero
    always_comb
    begin
        case (reg_addr)
            ADF_REG_FAULT:  rd_data = fault_q;
            ADF_REG_STATUS: rd_data = status_q;
            ADF_REG_CTRL:   rd_data = ctrl_q;
            default:        rd_data = 8'h00;
        endcase
    end

    // ==========================================================
    // Alert pin; high supply reported even in shutdown
    logic alert_q, diag_alert;
    // Open load alone never alerts
    assign diag_alert = status_q[ADF_SB_GND] | status_q[ADF_SB_SUP]
                      | status_q[ADF_SB_SHORT];
    always_ff @(posedge clk)
    begin
        if (sys_rst || !por_f_q)
            alert_q <= 1'b0;   // Released on supply loss
        else
            alert_q <= t.high | (active & (hard_fault | diag_alert));
    end
    assign alert_n_out = 1'b0;
    assign alert_n_oe  = alert_q;

    // ==========================================================
    // Output stage control
    always_ff @(posedge clk)
    begin
        if (sys_rst)
        begin
            out_hiz     <= 1'b1;
            out_play    <= 1'b0;
            diag_bias   <= 1'b0;
            limit_level <= 4'h0;
        end
        else
        begin
            out_hiz     <= st_q != ST_PLAY || hard_fault;
            out_play    <= st_q == ST_PLAY && !hard_fault;
            diag_bias   <= st_q == ST_DIAG;
            limit_level <= ctrl_q[ADF_LIM_LSB +: ADF_LIM_W];
        end
    end

endmodule

/* File: verification/adf_ctrl_monitor.sv */
`timescale 1ns/1ps

module adf_ctrl_monitor
    import adf_pkg::*;
(
    // Clock and reset
    input wire logic       clk,
    input wire logic       sys_rst,
    // Pins and levels watched
    input wire logic       shutdown_n,
    input wire logic       por_n,
    input wire logic       alert_n_out,
    input wire logic       alert_n_oe,
    input wire logic       scl_oe,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire adf_trip_s  trip,
    input wire logic       out_hiz,
    input wire logic       out_play,
    input wire logic       diag_bias,
    input wire logic [3:0] limit_level
);
    // ==========================================================
    // Eight samples span the input filters
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    chk_bus_target:
        assert property (!scl_oe && !sda_out && !alert_n_out)
        else $error("Pin driven high");
    chk_shut_quiet:
        assert property (!shutdown_n [*8] |-> !sda_oe && limit_level == 0)
        else $error("Shutdown not quiet");
    chk_por_quiet:
        assert property (!por_n [*8] |-> !sda_oe && !out_play)
        else $error("Supply loss not quiet");
    chk_diag_hiz:
        assert property (diag_bias |-> out_hiz && !out_play)
        else $error("Diag not Hi-Z");
    chk_play_after_diag:
        assert property ($rose(out_play) |-> $past(diag_bias))
        else $error("Play without diag");
    chk_oc_alert:
        assert property ((trip.oc && shutdown_n && por_n) [*8]
            |-> alert_n_oe && out_hiz)
        else $error("Overcurrent missed");
    chk_therm_down:
        assert property ((trip.therm && shutdown_n && por_n) [*8]
            |-> alert_n_oe && !out_play)
        else $error("Thermal missed");
    chk_low_reset:
        assert property ((trip.low && por_n) [*8]
            |-> alert_n_oe && limit_level == 0)
        else $error("Low supply missed");
    chk_high_alert:
        assert property ((trip.high && por_n) [*8] |-> alert_n_oe)
        else $error("High supply missed");
    chk_diag_abort:
        assert property ((trip.therm || trip.low) [*8] |-> !diag_bias)
        else $error("Diag not aborted");

    // Main scenarios reached
    cover property (out_play);
    cover property (alert_n_oe && trip.oc);
    cover property ($rose(sda_oe));
endmodule

bind adf_ctrl adf_ctrl_monitor adf_ctrl_monitor_inst (.*);

/* File: verification/adf_host.sv */
`timescale 1ns/1ps

module adf_host
#(
    parameter int QTR_NS = 625
)
(
    // Open-drain drives, high pulls the line low
    output logic      scl_low,
    output logic      sda_low,
    // Resolved data line
    input  wire logic sda_bus
);
    // ==========================================================
    // Bus controller; a 2.5 us bit keeps to 400 kbit/s
    initial {scl_low, sda_low} = 2'b00;

    // START: SDA falls while SCL high
    task automatic start();
        sda_low = 1'b0;
        #QTR_NS;
        scl_low = 1'b0;
        #QTR_NS;
        sda_low = 1'b1;
        #QTR_NS;
        scl_low = 1'b1;
    endtask

    // STOP: SDA rises while SCL high
    task automatic stop();
        sda_low = 1'b1;
        #QTR_NS;
        scl_low = 1'b0;
        #QTR_NS;
        sda_low = 1'b0;
        #QTR_NS;
    endtask

    // SDA moves while SCL is low
    task automatic bit_io(input logic b, output logic r);
        sda_low = !b;
        #QTR_NS;
        scl_low = 1'b0;
        #QTR_NS;
        r = sda_bus;
        #QTR_NS;
        scl_low = 1'b1;
        #QTR_NS;
    endtask

    // MSB first, ninth bit is the acknowledge
    task automatic byte_io(input logic [7:0] d, input logic mack,
                           output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], q[i]);
        bit_io(mack, ack);
    endtask
endmodule

/* File: verification/adf_ctrl_test.sv */
`timescale 1ns/1ps

module adf_ctrl_test import adf_pkg::*;;
    // ==========================================================
    // Bench signals; short counts keep the run brief
    localparam int DIAG = 200;
    localparam int WAKE = 20;
    logic       clk, sys_rst, shutdown_n, por_n, load_valid;
    logic       scl_low, sda_low, scl_oe, sda_oe, alert_n_oe;
    logic       out_hiz, out_play, diag_bias;
    logic [3:0] limit_level;
    logic [7:0] d [3];
    logic [6:0] tgt = ADF_DEV_ADDR;
    adf_trip_s  trip;
    adf_load_s  load;
    int         errors = 0, comparisons = 0;
    // Pull-ups on both lines
    wire        scl_bus = !(scl_low || scl_oe);
    wire        sda_bus = !(sda_low || sda_oe);

    adf_ctrl #(.DIAG_CYC(DIAG), .WAKE_CYC(WAKE)) adf_ctrl_inst (
        .clk, .sys_rst, .shutdown_n, .por_n, .alert_n_out(), .alert_n_oe,
        .scl_in(scl_bus), .sda_in(sda_bus), .scl_out(), .scl_oe,
        .sda_out(), .sda_oe, .trip, .load, .load_valid, .out_hiz,
        .out_play, .diag_bias, .limit_level);
    adf_host adf_host_inst (.*);

    always #12.5 clk = !clk;

    task automatic check(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask

    // Write one byte to target tgt; a foreign address gets no ack
    task automatic wr(input logic [7:0] sub, dat);
        logic [7:0] q;
        logic       a;
        logic [7:0] seq [3];
        seq = '{{tgt, 1'b0}, sub, dat};
        adf_host_inst.start();
        foreach (seq[i])
        begin
            adf_host_inst.byte_io(seq[i], 1'b1, q, a);
            check({7'h0, a}, {7'h0, tgt != ADF_DEV_ADDR});
        end
        adf_host_inst.stop();
    endtask

    // Read n bytes into d, NACK on the last
    task automatic rd(input logic [7:0] sub, input int n);
        logic [7:0] q;
        logic       a;
        adf_host_inst.start();
        adf_host_inst.byte_io({ADF_DEV_ADDR, 1'b0}, 1'b1, q, a);
        adf_host_inst.byte_io(sub, 1'b1, q, a);
        adf_host_inst.start();
        adf_host_inst.byte_io({ADF_DEV_ADDR, 1'b1}, 1'b1, q, a);
        check({7'h0, a}, 8'h00);
        for (int i = 0; i < n; i++)
        begin
            adf_host_inst.byte_io(8'hFF, i == n - 1, d[i], a);
        end
        adf_host_inst.stop();
    endtask

    task automatic t_wake();
        shutdown_n = 1'b1;
        por_n = 1'b1;
        cyc(WAKE + 10);
        check({7'h0, diag_bias & out_hiz}, 8'h01);
        cyc(DIAG + 40);
        check({6'h0, out_play, out_hiz}, 8'h02);
    endtask

    task automatic t_regs();
        wr(ADF_REG_CTRL, 8'h0A);
        check({4'h0, limit_level}, 8'h0A);
        wr(ADF_REG_FAULT, 8'hFF);
        rd(ADF_REG_FAULT, 3);
        check(d[0], 8'h00);
        check({7'h0, d[1][ADF_SB_PLAY]}, 8'h01);
        check(d[2], 8'h0A);
    endtask

    // Neighbour address: no ack, control untouched
    task automatic t_foreign();
        tgt ^= 7'h01;
        wr(ADF_REG_CTRL, 8'h05);
        tgt ^= 7'h01;
        check({4'h0, limit_level}, 8'h0A);
    endtask

    task automatic t_trips();
        trip.oc = 1'b1;
        cyc(20);
        check({6'h0, alert_n_oe, out_hiz}, 8'h03);
        trip.oc = 1'b0;
        cyc(10);
        check({7'h0, diag_bias}, 8'h01);
        rd(ADF_REG_FAULT, 1);
        check(d[0], 8'h08);
        trip.therm = 1'b1;
        cyc(20);
        check({6'h0, alert_n_oe, out_play}, 8'h02);
        trip.therm = 1'b0;
        cyc(2 * DIAG + 40);
        check({6'h0, alert_n_oe, out_play}, 8'h01);
        trip.low = 1'b1;
        cyc(20);
        check({3'h0, alert_n_oe, limit_level}, 8'h10);
        trip.low = 1'b0;
        rd(ADF_REG_FAULT, 1);
        check(d[0], 8'h10);
    endtask

    task automatic t_supply();
        wr(ADF_REG_CTRL, 8'h05);
        por_n = 1'b0;
        cyc(20);
        check({3'h0, sda_oe, limit_level}, 8'h00);
        por_n = 1'b1;
        cyc(WAKE + 20);
        rd(ADF_REG_CTRL, 1);
        check(d[0], ADF_CTRL_RESET);
        shutdown_n = 1'b0;
        trip.high = 1'b1;
        cyc(20);
        check({6'h0, alert_n_oe, sda_oe}, 8'h02);
        trip.high = 1'b0;
        load.open = 1'b1;
        shutdown_n = 1'b1;
        cyc(WAKE + DIAG + 40);
        check({7'h0, alert_n_oe}, 8'h00);
        rd(ADF_REG_STATUS, 1);
        check({7'h0, d[0][ADF_SB_OPEN]}, 8'h01);
        load.open = 1'b0;
        cyc(2 * DIAG + 40);
        check({7'h0, out_play}, 8'h01);
    endtask

    task automatic end_sim();
        if (errors == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        clk = 1'b0;
        sys_rst = 1'b1;
        {shutdown_n, por_n, trip, load} = '0;
        load_valid = 1'b1;
        cyc(6);
        sys_rst = 1'b0;
        t_wake();
        t_regs();
        t_foreign();
        t_trips();
        t_supply();
        end_sim();
    end

    // Watchdog: over twice the expected run
    initial
    begin
        #2_000_000;
        errors++;
        end_sim();
    end
endmodule
